// >>> logic/ubrg_pkg.sv
`default_nettype none

package ubrg_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // bus geometry
    localparam int           ADDR_W = 12;             // apb address width
    localparam int           DATA_W = 32;             // apb data width

    // register byte offsets
    localparam logic [11:0]  MODE_OFF = 12'h000;      // serial_mode_register
    localparam logic [11:0]  DIV_OFF  = 12'h004;      // baud_divisor_register
    localparam logic [11:0]  STAT_OFF = 12'h008;      // generator status, read only

    ////////////////////////////////////////////////////////////////////////////
    // field layout of the mode register
    localparam int           SYNC_BIT = 8;            // 0 async, 1 sync
    localparam int           CLOCK_SOURCE_SELECT_LSB = 4;            // clock_source_select low bit
    localparam int           CLOCK_SOURCE_SELECT_W   = 2;            // clock_source_select width
    localparam int           DIV_W    = 16;           // clock_divisor width

    // status register layout
    localparam int           STAT_RUN_BIT = 0;        // baud clock enabled
    localparam int           STAT_PIN_BIT = 1;        // synchronised pin level
    localparam int           STAT_PH_LSB  = 4;        // oversample phase

    // reset values
    localparam logic         SYNC_RST = 1'b0;
    localparam logic [1:0]   CLOCK_SOURCE_SELECT_RST = 2'h0;
    localparam logic [15:0]  DIV_RST  = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // clock source codes
    localparam logic [1:0]   CLOCK_SOURCE_SELECT_PCLK  = 2'h0;       // undivided pclk
    localparam logic [1:0]   CLOCK_SOURCE_SELECT_PCLK8 = 2'h1;       // pclk over eight

    // divider constants
    localparam logic [2:0]   PRE_LAST   = 3'h7;       // last state of the /8 prescaler
    localparam logic [3:0]   OVER_LAST  = 4'hF;       // last of sixteen samples per bit
    localparam logic [3:0]   OVER_FIRST = 4'h0;       // oversample phase after a bit

endpackage : ubrg_pkg

`default_nettype wire

// >>> logic/ubrg_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module ubrg_pin_sync (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // raw pin from the far party
    input  wire logic pin_in,
    // synchronised view
    output logic      pin_level,
    output logic      pin_rise
);

    logic meta_reg;     // first stage, read only by the second
    logic sync_reg;     // second stage, safe to use
    logic hist_reg;     // previous safe value for edge detect
    logic rise_reg;     // one-cycle rising edge pulse

    ////////////////////////////////////////////////////////////////////////////
    // two-flop synchroniser; the pin is never used as a clock
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end
        else
        begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
        end
    end

    // edge detect only on the settled stage
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hist_reg <= 1'b0;
            rise_reg <= 1'b0;
        end
        else
        begin
            hist_reg <= sync_reg;
            rise_reg <= sync_reg & ~hist_reg;
        end
    end

    assign pin_level = hist_reg;
    assign pin_rise  = rise_reg;

endmodule : ubrg_pin_sync

`default_nettype wire

// >>> logic/ubrg_baud_gen.sv
`timescale 1ns/1ps
`default_nettype none

module ubrg_baud_gen (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // external serial clock, input side only
    input  wire logic        ext_serial_clock_pin,
    // timing strobes to receiver and transmitter
    output logic             baud_tick,
    output logic             rx_sample_tick
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    logic        sync_mode_reg;             // serial_mode_register sync bit
    logic [1:0]  clock_source_select_reg;   // clock_source_select field
    logic [15:0] clock_divisor_reg;         // baud_divisor_register contents
    logic [2:0]  pre_cnt_reg;               // pclk/8 prescaler state
    logic        pre_tick_reg;              // one pulse every eight pclk
    logic [15:0] div_cnt_reg;               // divisor counter
    logic [3:0]  over_cnt_reg;              // sixteen-sample phase
    logic        sample_tick_reg;           // 16x oversample pulse
    logic        baud_tick_reg;             // bit period pulse
    logic        rx_sample_reg;             // receiver sample strobe
    logic [31:0] prdata_reg;                // captured read data
    logic        pin_level;                 // synchronised pin level
    logic        pin_rise;                  // synchronised pin rising edge
    logic        ext_direct;                // sync mode fed straight from pin
    logic        src_en;                    // one pulse per selected source period
    logic        div_zero;                  // divisor programmed to zero
    logic        div_hit;                   // divisor counter wraps this cycle
    logic        apb_access;                // access phase of any transfer
    logic        cfg_wr;                    // write to mode or divisor
    logic [31:0] rd_word;                   // read mux output

    ////////////////////////////////////////////////////////////////////////////
    // address decode for the error answer; the read mux decodes paddr in its own case
    function automatic logic ubrg_is_mapped(input logic [11:0] addr);
        ubrg_is_mapped = (addr == ubrg_pkg::MODE_OFF) ||
                         (addr == ubrg_pkg::DIV_OFF)  ||
                         (addr == ubrg_pkg::STAT_OFF);
    endfunction : ubrg_is_mapped

    ////////////////////////////////////////////////////////////////////////////
    // pin synchroniser
    // pin synchronised first
    ubrg_pin_sync u_pin_sync (
        .pclk      (pclk),
        .presetn   (presetn),
        .pin_in    (ext_serial_clock_pin),
        .pin_level (pin_level),
        .pin_rise  (pin_rise)
    );

    ////////////////////////////////////////////////////////////////////////////
    // apb decode; zero wait states, so pready is a constant handshake
    assign apb_access = psel & penable;
    assign pready     = 1'b1;
    // unmapped offsets answer with an error and leave state alone
    assign pslverr    = apb_access & ~ubrg_is_mapped(paddr);
    assign cfg_wr     = apb_access & pwrite &
                        ((paddr == ubrg_pkg::MODE_OFF) || (paddr == ubrg_pkg::DIV_OFF));

    // mode register write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_mode_reg           <= ubrg_pkg::SYNC_RST;
            clock_source_select_reg <= ubrg_pkg::CLOCK_SOURCE_SELECT_RST;
        end
        else if (apb_access && pwrite && paddr == ubrg_pkg::MODE_OFF)
        begin
            sync_mode_reg           <= pwdata[ubrg_pkg::SYNC_BIT];
            clock_source_select_reg <= pwdata[ubrg_pkg::CLOCK_SOURCE_SELECT_LSB +: ubrg_pkg::CLOCK_SOURCE_SELECT_W];
        end
    end

    // divisor register write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            clock_divisor_reg <= ubrg_pkg::DIV_RST;
        end
        else if (apb_access && pwrite && paddr == ubrg_pkg::DIV_OFF)
        begin
            clock_divisor_reg <= pwdata[ubrg_pkg::DIV_W-1:0];
        end
    end

    // read mux; reserved bits read as zero
    always_comb
    begin
        rd_word = 32'h0000_0000;
        case (paddr)
            ubrg_pkg::MODE_OFF:
            begin
                rd_word[ubrg_pkg::SYNC_BIT]                     = sync_mode_reg;
                rd_word[ubrg_pkg::CLOCK_SOURCE_SELECT_LSB +: ubrg_pkg::CLOCK_SOURCE_SELECT_W] = clock_source_select_reg;
            end
            ubrg_pkg::DIV_OFF:
            begin
                rd_word[ubrg_pkg::DIV_W-1:0] = clock_divisor_reg;
            end
            ubrg_pkg::STAT_OFF:
            begin
                // live state of the generator
                rd_word[ubrg_pkg::STAT_RUN_BIT] = ext_direct | ~div_zero;
                rd_word[ubrg_pkg::STAT_PIN_BIT] = pin_level;
                rd_word[ubrg_pkg::STAT_PH_LSB +: $bits(over_cnt_reg)] = over_cnt_reg;
            end
            default:
            begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    // read data captured in the setup phase so prdata comes from a flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_reg <= 32'h0000_0000;
        end
        else if (psel && !penable && !pwrite)
        begin
            prdata_reg <= rd_word;
        end
    end

    assign prdata = prdata_reg;

    ////////////////////////////////////////////////////////////////////////////
    // pclk over eight prescaler, free running so its phase never depends on
    // when software picked it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pre_cnt_reg  <= 3'h0;
            pre_tick_reg <= 1'b0;
        end
        else
        begin
            pre_cnt_reg  <= pre_cnt_reg + 3'h1;
            pre_tick_reg <= (pre_cnt_reg == ubrg_pkg::PRE_LAST);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // source selection
    always_comb
    begin
        case (clock_source_select_reg)
            ubrg_pkg::CLOCK_SOURCE_SELECT_PCLK:  src_en = 1'b1;
            ubrg_pkg::CLOCK_SOURCE_SELECT_PCLK8: src_en = pre_tick_reg;
            // upper bit set: edges of the pin
            default:              src_en = pin_rise;
        endcase
    end

    assign ext_direct = sync_mode_reg & clock_source_select_reg[1];
    assign div_zero   = (clock_divisor_reg == ubrg_pkg::DIV_RST);
    assign div_hit    = src_en & ~div_zero & ~ext_direct &
                        (div_cnt_reg >= (clock_divisor_reg - 16'h0001));

    ////////////////////////////////////////////////////////////////////////////
    // divisor counter; a config write restarts it so a new rate starts clean
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_cnt_reg <= 16'h0000;
        end
        else if (cfg_wr || div_zero || ext_direct)
        begin
            div_cnt_reg <= 16'h0000;
        end
        else if (div_hit)
        begin
            div_cnt_reg <= 16'h0000;
        end
        else if (src_en)
        begin
            div_cnt_reg <= div_cnt_reg + 16'h0001;
        end
    end

    // sixteen-sample phase, only used in async mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            over_cnt_reg <= ubrg_pkg::OVER_FIRST;
        end
        else if (cfg_wr || sync_mode_reg)
        begin
            over_cnt_reg <= ubrg_pkg::OVER_FIRST;
        end
        else if (div_hit)
        begin
            over_cnt_reg <= (over_cnt_reg == ubrg_pkg::OVER_LAST) ?
                            ubrg_pkg::OVER_FIRST : over_cnt_reg + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output strobes, all registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sample_tick_reg <= 1'b0;
            baud_tick_reg   <= 1'b0;
            rx_sample_reg   <= 1'b0;
        end
        else
        begin
            sample_tick_reg <= ~sync_mode_reg & div_hit;
            if (ext_direct)
            begin
                baud_tick_reg <= pin_rise;
            end
            else if (sync_mode_reg)
            begin
                baud_tick_reg <= div_hit;
            end
            else
            begin
                baud_tick_reg <= div_hit & (over_cnt_reg == ubrg_pkg::OVER_LAST);
            end
            rx_sample_reg <= sync_mode_reg ? pin_rise : div_hit;
        end
    end

    assign baud_tick      = baud_tick_reg;
    assign rx_sample_tick = rx_sample_reg;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_zero_div_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        (div_zero && !ext_direct && $past(div_zero) && !$past(ext_direct))
        |-> !baud_tick_reg && !sample_tick_reg)
        else $error("baud strobe while divisor is zero");

    a_sync_zero_off: assert property (@(posedge pclk) disable iff (!presetn)
        (sync_mode_reg && !clock_source_select_reg[1] && div_zero)
        |=> !baud_tick_reg)
        else $error("sync internal baud tick with zero divisor");

    a_async_sixteen: assert property (@(posedge pclk) disable iff (!presetn)
        (!$past(sync_mode_reg) && baud_tick_reg)
        |-> sample_tick_reg && over_cnt_reg == ubrg_pkg::OVER_FIRST)
        else $error("async bit tick not on sixteenth sample");

    a_pclk_full_rate: assert property (@(posedge pclk) disable iff (!presetn)
        (!sync_mode_reg && clock_source_select_reg == ubrg_pkg::CLOCK_SOURCE_SELECT_PCLK &&
         clock_divisor_reg == 16'h0001)
        |=> sample_tick_reg)
        else $error("pclk source with divisor one missed a sample");

    a_prescale_eight: assert property (@(posedge pclk) disable iff (!presetn)
        pre_tick_reg |=> !pre_tick_reg [*7] ##1 pre_tick_reg)
        else $error("prescaler pulse not every eight cycles");

    a_sync_div_two: assert property (@(posedge pclk) disable iff (!presetn)
        (baud_tick_reg && !psel && sync_mode_reg &&
         clock_source_select_reg == ubrg_pkg::CLOCK_SOURCE_SELECT_PCLK && clock_divisor_reg == 16'h0002)
        |=> !baud_tick_reg ##1 baud_tick_reg)
        else $error("sync divide by two wrong spacing");

    a_ext_direct: assert property (@(posedge pclk) disable iff (!presetn)
        (ext_direct && pin_rise) |=> baud_tick_reg)
        else $error("external pin edge not passed as baud tick");

    a_sync_rx_edge: assert property (@(posedge pclk) disable iff (!presetn)
        (sync_mode_reg && pin_rise) |=> rx_sample_reg)
        else $error("sync receiver missed a pin rising edge");

    a_mode_sync_bit: assert property (@(posedge pclk) disable iff (!presetn)
        (apb_access && pwrite && paddr == ubrg_pkg::MODE_OFF)
        |=> sync_mode_reg == $past(pwdata[ubrg_pkg::SYNC_BIT]))
        else $error("mode bit eight not stored");

    a_edge_single: assert property (@(posedge pclk) disable iff (!presetn)
        pin_rise |=> !pin_rise)
        else $error("pin edge pulse longer than one cycle");

endmodule : ubrg_baud_gen

`default_nettype wire

// >>> dv/ubrg_pin_partner.sv
`timescale 1ns/1ps
`default_nettype none

// far party driving the serial clock pin; it stands still low while idle
module ubrg_pin_partner (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // control from the bench
    input  wire logic       run,
    input  wire logic [3:0] half,
    // serial clock towards the generator
    output logic            pin
);
    logic [3:0] cnt_reg;  // cycles spent in the current level

    ////////////////////////////////////////////////////////////////////////////
    // level generator; half of at least 2 keeps the rate at 25 percent or less
    // slow wide levels
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin     <= 1'b0;
            cnt_reg <= 4'h0;
        end
        else if (!run)
        begin
            // outside frames the clock does not run
            pin     <= 1'b0;
            cnt_reg <= 4'h0;
        end
        // a shorter half set while running ends the level at once instead of
        // letting the counter wrap into one long irregular level
        else if (cnt_reg >= half - 4'h1)
        begin
            pin     <= ~pin;
            cnt_reg <= 4'h0;
        end
        else
            cnt_reg <= cnt_reg + 4'h1;
    end
endmodule : ubrg_pin_partner

`default_nettype wire

// >>> dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic        pclk = 1'b0, presetn = 1'b0;           // clock and reset
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;                        // apb request
    logic [31:0] pwdata = 32'h00000000, prdata;
    logic        pready, pslverr, baud_tick, rx_sample_tick;
    logic        pin, pin_run = 1'b0;                    // partner pin
    logic [3:0]  pin_half = 4'h2;
    int          n_errors = 0, samples_checked = 0;
    logic [31:0] q;
    logic        e, sy;
    logic [1:0]  cs;
    int          dv, k;

    always #5 pclk = ~pclk;

    ubrg_baud_gen DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_serial_clock_pin(pin), .baud_tick(baud_tick),
        .rx_sample_tick(rx_sample_tick));
    ubrg_pin_partner PARTNER (.pclk(pclk), .presetn(presetn), .run(pin_run), .half(pin_half),
        .pin(pin));

    ////////////////////////////////////////////////////////////////////////////
    // verdict and end of run
    task results;
        $display("checked %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results

    task chk_val(input logic [31:0] got, input logic [31:0] exp, input string m);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk_val

    task chk_cnt(input int got, input int exp, input string m);
        samples_checked++;
        if (got != exp)
        begin
            n_errors++;
            $display("MISMATCH %0t %s got %0d exp %0d", $time, m, got, exp);
        end
    endtask : chk_cnt

    ////////////////////////////////////////////////////////////////////////////
    // one apb transfer; held until pready is seen high at a rising edge
    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            n_errors++;
            $display("MISMATCH %0t apb answer timeout", $time);
            results();
        end
    endtask : apb

    // cycles between two strobes, or strobe count over a window when none expected
    task measure(input logic which, input int exp, input string m);
        int n, c;
        n = 0;
        c = 0;
        if (exp == 0)
        begin
            repeat (700)
            begin
                @(negedge pclk);
                c += ((which ? baud_tick : rx_sample_tick) === 1'b1);
            end
            chk_cnt(c, 0, m);
            return;
        end
        // skip the restart interval, then time a full one; each wait is bounded
        repeat (2)
        begin
            n = 0;
            do
            begin
                @(negedge pclk);
                n++;
            end
            while ((which ? baud_tick : rx_sample_tick) !== 1'b1 && n < 4000);
            if ((which ? baud_tick : rx_sample_tick) !== 1'b1)
            begin
                n_errors++;
                $display("MISMATCH %0t %s strobe timeout", $time, m);
                results();
            end
        end
        chk_cnt(n, exp, m);
    endtask : measure

    ////////////////////////////////////////////////////////////////////////////
    // expected periods in pclk cycles; 0 means the strobe stays quiet
    function automatic int src_per(input logic [1:0] c, input logic [3:0] h);
        return (c == 2'h0) ? 1 : (c == 2'h1) ? 8 : 2 * int'(h);
    endfunction : src_per

    function automatic int exp_baud(input logic s, input logic [1:0] c, input int d,
                                    input logic [3:0] h);
        if (s && c[1]) return 2 * int'(h);
        if (d == 0) return 0;
        return s ? src_per(c, h) * d : 16 * src_per(c, h) * d;
    endfunction : exp_baud

    function automatic int exp_rx(input logic s, input logic [1:0] c, input int d,
                                  input logic [3:0] h);
        if (s) return c[1] ? 2 * int'(h) : 0;
        return (d == 0) ? 0 : src_per(c, h) * d;
    endfunction : exp_rx

    // program one configuration and time both strobes
    task run_case(input logic s, input logic [1:0] c, input int d, input logic [3:0] h);
        @(posedge pclk);
        pin_half <= h;
        pin_run  <= c[1];
        apb(12'h004, 1'b1, 32'(d));
        apb(12'h000, 1'b1, {23'h0, s, 2'h0, c, 4'h0});
        apb(12'h008, 1'b0, 32'h0);
        // status bit zero shows a running generator
        chk_val(q & 32'h1, 32'((d != 0) || (s && c[1])), "status run");
        measure(1'b1, exp_baud(s, c, d, h), "baud period");
        measure(1'b0, exp_rx(s, c, d, h), "sample period");
    endtask : run_case

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        void'($urandom(32'h0396AD8E));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        // reset values and a quiet baud strobe
        apb(12'h000, 1'b0, 32'h0);
        chk_val(q, 32'h00000000, "mode reset");
        apb(12'h004, 1'b0, 32'h0);
        chk_val(q, 32'h00000000, "divisor reset");
        measure(1'b1, 0, "baud after reset");
        // field widths and reserved bits read as zero
        apb(12'h000, 1'b1, 32'hFFFFFFFF);
        apb(12'h000, 1'b0, 32'h0);
        chk_val(q, 32'h00000130, "mode fields");
        apb(12'h004, 1'b1, 32'hFFFFABCD);
        apb(12'h004, 1'b0, 32'h0);
        chk_val(q, 32'h0000ABCD, "divisor field");
        // unmapped place answers with an error and zero data
        apb(12'h00C, 1'b0, 32'h0);
        chk_val({31'h0, e}, 32'h1, "unmapped error");
        chk_val(q, 32'h00000000, "unmapped data");
        // writes to the status word or an unmapped place change nothing
        apb(12'h00C, 1'b1, 32'hFFFFFFFF);
        chk_val({31'h0, e}, 32'h1, "unmapped write error");
        apb(12'h008, 1'b1, 32'hFFFFFFFF);
        chk_val({31'h0, e}, 32'h0, "status write error");
        apb(12'h000, 1'b0, 32'h0);
        chk_val(q, 32'h00000130, "mode after ignored writes");
        // corner cases: divisor one, zero divisor, pin with divisor ignored
        run_case(1'b0, 2'h0, 1, 4'h2);
        run_case(1'b0, 2'h1, 2, 4'h2);
        run_case(1'b0, 2'h1, 0, 4'h2);
        run_case(1'b1, 2'h0, 0, 4'h2);
        run_case(1'b1, 2'h0, 3, 4'h2);
        run_case(1'b1, 2'h0, 2, 4'h2);
        run_case(1'b1, 2'h1, 2, 4'h2);
        run_case(1'b1, 2'h2, 0, 4'h3);
        run_case(1'b1, 2'h3, 5, 4'h5);
        run_case(1'b0, 2'h2, 2, 4'h2);
        // random mix of modes, sources, divisors and pin rates
        for (k = 0; k < 12; k++)
        begin
            sy = 1'($urandom % 2);
            cs = 2'($urandom % 4);
            dv = $urandom % 5;
            run_case(sy, cs, dv, 4'(2 + $urandom % 4));
        end
        // reset in mid-run clears the divisor and status words and quiets the generator
        @(posedge pclk);
        pin_run <= 1'b0;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(12'h004, 1'b0, 32'h0);
        chk_val(q, 32'h00000000, "divisor after second reset");
        apb(12'h008, 1'b0, 32'h0);
        chk_val(q, 32'h00000000, "status after second reset");
        measure(1'b1, 0, "baud after second reset");
        results();
    end
endmodule : tb_top

`default_nettype wire
